// ### core/gpio_edge_interrupt_bank.sv
// pin sampling and edge-triggered interrupt registers on an axi4-lite slave
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
// What this block does
// - Pin-level bits read the pin's current logic level, 0 low, 1 high.
// - Banks 0/1 word: bank 1 in bits 31-16, bank 0 in 15-0; bank 2 uses 15-0.
// - Writing 1 to a rise-enable-set bit enables rising-edge interrupts; 0 does nothing.
// - Writing 1 to a rise-enable-clear bit disables rising-edge interrupts; 0 does nothing.
// - Writing 1 to a fall-enable-set bit enables falling-edge interrupts; 0 does nothing.
// - Writing 1 to a fall-enable-clear bit disables falling-edge interrupts; 0 does nothing.
// - A status bit reads 1 while that pin's interrupt is pending, else 0.
// - Set registers read the enable state; clear registers read its complement.
// - Positions without a pin are read-only and read 0.
// - After reset all enables and status bits are 0.
// - Input pins are seen through a synchroniser to the peripheral clock.
// - Output pins read back the value being driven.
// - Writing 1 clears a status bit; writing 0 leaves it.
module gpio_edge_interrupt_bank (
    // clock, reset, freeze
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address
    input wire logic [gpio_edge_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [gpio_edge_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // pins, asynchronous
    input wire logic [31:0] pin_in_banks01,
    input wire logic [15:0] pin_in_bank2,
    // pin configuration from the output logic, same clock
    input wire logic [31:0] pin_direction_banks01,
    input wire logic [15:0] pin_direction_bank2,
    input wire logic [31:0] pin_drive_banks01,
    input wire logic [15:0] pin_drive_bank2,
    // interrupt
    output logic irq
);

    typedef struct packed {
        logic aw_held;
        logic [5:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0][31:0] rise;
        logic [1:0][31:0] fall;
        logic [1:0][31:0] pend;
        logic [1:0][31:0] irq_mask;
    } bank_state_t;

    bank_state_t s_reg;
    bank_state_t s_next;

    logic [1:0][31:0] pin_raw;
    logic [1:0][31:0] drive;
    logic [1:0][31:0] dir_in;
    logic [1:0][31:0] level;
    logic [1:0][31:0] ev;

    logic aw_take;
    logic w_take;
    logic aw_have;
    logic w_have;
    logic wr_fire;
    logic [5:0] wr_addr;
    logic [5:0] wr_base;
    logic wr_word;
    logic [31:0] wr_data;
    logic [31:0] wr_bits;
    logic [31:0] strobe_bits;
    logic rd_take;
    logic [5:0] rd_base;
    logic rd_word;

    // bank 2 occupies the low half of its own word
    assign pin_raw[0] = pin_in_banks01;
    assign pin_raw[1] = {16'h0000, pin_in_bank2};
    assign drive[0] = pin_drive_banks01;
    assign drive[1] = {16'h0000, pin_drive_bank2};
    // direction 1 = input, 0 = output
    assign dir_in[0] = pin_direction_banks01;
    assign dir_in[1] = {16'h0000, pin_direction_bank2};

    for (genvar w = 0; w < gpio_edge_pkg::WORDS; w++) begin : g_word
        pin_word_sampler #(
            .WIDTH(32),
            .MASK(gpio_edge_pkg::WORD_MASK[w])
        ) u_sampler (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .pin_raw(pin_raw[w]),
            .drive_value(drive[w]),
            .direction_in(dir_in[w]),
            .rise_en(s_reg.rise[w]),
            .fall_en(s_reg.fall[w]),
            .level(level[w]),
            .edge_event(ev[w])
        );
    end

    // one write in flight: both channels stall while the response waits
    assign awready = ce & ~s_reg.aw_held & ~s_reg.bvalid;
    assign wready = ce & ~s_reg.w_held & ~s_reg.bvalid;
    assign arready = ce & ~s_reg.rvalid;

    assign aw_take = awvalid & awready;
    assign w_take = wvalid & wready;
    assign aw_have = s_reg.aw_held | aw_take;
    assign w_have = s_reg.w_held | w_take;
    assign wr_fire = ce & aw_have & w_have & ~s_reg.bvalid;

    always_comb begin
        strobe_bits = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            strobe_bits[b*8 +: 8] = {8{wstrb[b]}};
        end
    end

    // unstrobed bytes become zero, which is "no effect" for every register except the mask, where they write 0
    assign wr_addr = s_reg.aw_held ? s_reg.aw_addr : awaddr;
    assign wr_data = s_reg.w_held ? s_reg.w_data : (wdata & strobe_bits);
    assign wr_base = {wr_addr[5:3], 3'b000};
    assign wr_word = wr_addr[2];
    assign wr_bits = wr_data & gpio_edge_pkg::WORD_MASK[wr_word];

    assign rd_take = arvalid & arready;
    assign rd_base = {araddr[5:3], 3'b000};
    assign rd_word = araddr[2];

    always_comb begin
        logic [1:0][31:0] pend_clr;
        logic [31:0] rd_val;
        pend_clr = '0;
        rd_val = 32'h0000_0000;
        s_next = s_reg;
        if (ce) begin
            if (aw_take) begin
                s_next.aw_held = 1'b1;
                s_next.aw_addr = awaddr;
            end
            if (w_take) begin
                s_next.w_held = 1'b1;
                s_next.w_data = wdata & strobe_bits;
            end
            if (s_reg.bvalid && bready) begin
                s_next.bvalid = 1'b0;
            end
            if (wr_fire) begin
                s_next.aw_held = 1'b0;
                s_next.w_held = 1'b0;
                s_next.bvalid = 1'b1;
                s_next.bresp = (wr_addr < gpio_edge_pkg::OFF_LIMIT) ?
                    gpio_edge_pkg::RESP_OKAY : gpio_edge_pkg::RESP_DECERR;
                case (wr_base)
                    gpio_edge_pkg::OFF_RISE_SET: begin
                        s_next.rise[wr_word] = s_reg.rise[wr_word] | wr_bits;
                    end
                    gpio_edge_pkg::OFF_RISE_CLR: begin
                        s_next.rise[wr_word] = s_reg.rise[wr_word] & ~wr_bits;
                    end
                    gpio_edge_pkg::OFF_FALL_SET: begin
                        s_next.fall[wr_word] = s_reg.fall[wr_word] | wr_bits;
                    end
                    gpio_edge_pkg::OFF_FALL_CLR: begin
                        s_next.fall[wr_word] = s_reg.fall[wr_word] & ~wr_bits;
                    end
                    gpio_edge_pkg::OFF_PEND: begin
                        pend_clr[wr_word] = wr_bits;
                    end
                    gpio_edge_pkg::OFF_MASK: begin
                        s_next.irq_mask[wr_word] = wr_bits;
                    end
                    default: begin
                        // level words are read-only; unmapped answers with an error
                    end
                endcase
            end
            // a new edge wins over a clear landing in the same cycle
            for (int w = 0; w < gpio_edge_pkg::WORDS; w++) begin
                s_next.pend[w] = (s_reg.pend[w] & ~pend_clr[w]) | ev[w];
            end
            if (s_reg.rvalid && rready) begin
                s_next.rvalid = 1'b0;
            end
            if (rd_take) begin
                case (rd_base)
                    gpio_edge_pkg::OFF_LEVEL: rd_val = level[rd_word];
                    gpio_edge_pkg::OFF_RISE_SET: rd_val = s_reg.rise[rd_word];
                    gpio_edge_pkg::OFF_RISE_CLR: rd_val = ~s_reg.rise[rd_word];
                    gpio_edge_pkg::OFF_FALL_SET: rd_val = s_reg.fall[rd_word];
                    gpio_edge_pkg::OFF_FALL_CLR: rd_val = ~s_reg.fall[rd_word];
                    gpio_edge_pkg::OFF_PEND: rd_val = s_reg.pend[rd_word];
                    gpio_edge_pkg::OFF_MASK: rd_val = s_reg.irq_mask[rd_word];
                    default: rd_val = 32'h0000_0000;
                endcase
                s_next.rvalid = 1'b1;
                s_next.rdata = rd_val & gpio_edge_pkg::WORD_MASK[rd_word];
                s_next.rresp = (araddr < gpio_edge_pkg::OFF_LIMIT) ?
                    gpio_edge_pkg::RESP_OKAY : gpio_edge_pkg::RESP_DECERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.rise <= {2{gpio_edge_pkg::REG_RESET}};
            s_reg.fall <= {2{gpio_edge_pkg::REG_RESET}};
            s_reg.pend <= {2{gpio_edge_pkg::REG_RESET}};
            s_reg.irq_mask <= {2{gpio_edge_pkg::REG_RESET}};
        end else begin
            s_reg <= s_next;
        end
    end

    assign bvalid = s_reg.bvalid;
    assign bresp = s_reg.bresp;
    assign rvalid = s_reg.rvalid;
    assign rdata = s_reg.rdata;
    assign rresp = s_reg.rresp;
    assign irq = |((s_reg.pend[0] & s_reg.irq_mask[0]) | (s_reg.pend[1] & s_reg.irq_mask[1]));

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_write_done;
        wr_fire;
    endsequence

    sequence s_resp_up;
        s_reg.bvalid && bresp == (($past(wr_addr) < gpio_edge_pkg::OFF_LIMIT) ?
            gpio_edge_pkg::RESP_OKAY : gpio_edge_pkg::RESP_DECERR);
    endsequence

    a_write_resp: assert property (s_write_done |=> s_resp_up)
        else $error("write taken without a response");

    a_rise_set_or: assert property (
        wr_fire && wr_addr == gpio_edge_pkg::OFF_RISE_SET
        |=> s_reg.rise[0] == ($past(s_reg.rise[0]) | $past(wr_bits)))
        else $error("rise enable set write misapplied");

    a_rise_clr_and: assert property (
        wr_fire && wr_addr == gpio_edge_pkg::OFF_RISE_CLR
        |=> s_reg.rise[0] == ($past(s_reg.rise[0]) & ~$past(wr_bits)))
        else $error("rise enable clear write misapplied");

    a_fall_set_or: assert property (
        wr_fire && wr_addr == (gpio_edge_pkg::OFF_FALL_SET | gpio_edge_pkg::WORD_STRIDE)
        |=> s_reg.fall[1] == ($past(s_reg.fall[1]) | $past(wr_bits)))
        else $error("fall enable set write misapplied");

    a_fall_clr_and: assert property (
        wr_fire && wr_addr == gpio_edge_pkg::OFF_FALL_CLR
        |=> s_reg.fall[0] == ($past(s_reg.fall[0]) & ~$past(wr_bits)))
        else $error("fall enable clear write misapplied");

    a_pend_w1c: assert property (
        wr_fire && wr_addr == gpio_edge_pkg::OFF_PEND && ev[0] == 32'h0000_0000
        |=> s_reg.pend[0] == ($past(s_reg.pend[0]) & ~$past(wr_bits)))
        else $error("status write-one-to-clear misapplied");

    a_event_sets: assert property (
        ce && ev[0] != 32'h0000_0000
        |=> (s_reg.pend[0] & $past(ev[0])) == $past(ev[0]))
        else $error("edge event did not set its status bit");

    a_enable_hold: assert property (
        !wr_fire |=> $stable(s_reg.rise) && $stable(s_reg.fall))
        else $error("enables changed without a write");

    a_reserved_zero: assert property (
        ((s_reg.rise[1] | s_reg.fall[1] | s_reg.pend[1]) & ~gpio_edge_pkg::MASK_BANK2)
        == 32'h0000_0000)
        else $error("reserved bit set in bank 2 word");

    a_clear_reads_comp: assert property (
        rd_take && araddr == gpio_edge_pkg::OFF_RISE_CLR
        |=> rvalid && rdata == (~$past(s_reg.rise[0]) & gpio_edge_pkg::MASK_BANKS01))
        else $error("clear register did not read the complement");

    a_level_reads: assert property (
        rd_take && araddr == gpio_edge_pkg::OFF_LEVEL
        |=> rdata == $past(level[0]))
        else $error("level read does not match sampled pins");

    a_read_holds: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped before it was taken");

    a_irq_level: assert property (
        ((s_reg.pend[1] & s_reg.irq_mask[1]) != 32'h0000_0000) |-> irq)
        else $error("unmasked pending bit without interrupt");

    sequence s_read_taken;
        rd_take;
    endsequence

    sequence s_read_up;
        s_reg.rvalid && rresp == (($past(araddr) < gpio_edge_pkg::OFF_LIMIT) ?
            gpio_edge_pkg::RESP_OKAY : gpio_edge_pkg::RESP_DECERR);
    endsequence

    a_read_resp: assert property (s_read_taken |=> s_read_up)
        else $error("read taken without its response");

    // a low enable must hold every register, bus handshakes included
    a_freeze_state: assert property (!ce |=> $stable(s_reg))
        else $error("state moved while the clock enable was low");

    a_frozen_ready: assert property (!ce |-> !awready && !wready && !arready)
        else $error("handshake ready while frozen");

    a_pend_clear_hi: assert property (
        wr_fire && ev[1] == 32'h0000_0000
        && wr_addr == (gpio_edge_pkg::OFF_PEND | gpio_edge_pkg::WORD_STRIDE)
        |=> s_reg.pend[1] == ($past(s_reg.pend[1]) & ~$past(wr_bits)))
        else $error("bank 2 status write-one-to-clear misapplied");

    a_level_hi: assert property (
        rd_take && araddr == (gpio_edge_pkg::OFF_LEVEL | gpio_edge_pkg::WORD_STRIDE)
        |=> rdata == ($past(level[1]) & gpio_edge_pkg::MASK_BANK2))
        else $error("bank 2 level read misplaced");

    a_edge_enabled: assert property (
        (ev[0] & ~(s_reg.rise[0] | s_reg.fall[0])) == 32'h0000_0000)
        else $error("edge event on a pin with no enabled direction");

endmodule : gpio_edge_interrupt_bank

// ### core/gpio_edge_pkg.sv
// constants shared by the edge-interrupt bank and its pin samplers
package gpio_edge_pkg;

    // register bus geometry
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int WORDS = 2;

    // register byte offsets, word 0 = banks 0/1, word 1 (+4) = bank 2
    localparam logic [5:0] OFF_LEVEL = 6'h00;
    localparam logic [5:0] OFF_RISE_SET = 6'h08;
    localparam logic [5:0] OFF_RISE_CLR = 6'h10;
    localparam logic [5:0] OFF_FALL_SET = 6'h18;
    localparam logic [5:0] OFF_FALL_CLR = 6'h20;
    localparam logic [5:0] OFF_PEND = 6'h28;
    localparam logic [5:0] OFF_MASK = 6'h30;
    localparam logic [5:0] OFF_LIMIT = 6'h38;
    localparam logic [5:0] WORD_STRIDE = 6'h04;

    // implemented pin positions per word
    localparam logic [31:0] MASK_BANKS01 = 32'h07FF_3DFF;
    localparam logic [31:0] MASK_BANK2 = 32'h0000_07F3;
    localparam logic [1:0][31:0] WORD_MASK = {MASK_BANK2, MASK_BANKS01};

    // value of every enable, status and mask bit after reset
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // cycles after reset before edges are trusted (sync + level + history)
    localparam logic [2:0] WARM_CYCLES = 3'h4;

endpackage : gpio_edge_pkg

// ### core/pin_word_sampler.sv
// synchroniser, level select and edge detector for one 32-pin register word
`timescale 1ns/1ps
module pin_word_sampler #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] MASK = '1
) (
    // clock, reset, freeze
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // pin side
    input wire logic [WIDTH-1:0] pin_raw,
    input wire logic [WIDTH-1:0] drive_value,
    input wire logic [WIDTH-1:0] direction_in,
    // edge enables
    input wire logic [WIDTH-1:0] rise_en,
    input wire logic [WIDTH-1:0] fall_en,
    // results
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] edge_event
);

    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("pin_word_sampler: WIDTH must be 1 to 32");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] lvl;
        logic [WIDTH-1:0] prev;
        logic [2:0] warm;
    } sampler_t;

    sampler_t s_reg;
    sampler_t s_next;
    logic armed;

    // history is meaningless until the pipeline has filled once
    assign armed = (s_reg.warm == gpio_edge_pkg::WARM_CYCLES);

    always_comb begin
        s_next = s_reg;
        if (ce) begin
            s_next.meta = pin_raw;
            s_next.sync = s_reg.meta;
            // inputs show the synchronised pin, outputs the driven value
            s_next.lvl = ((direction_in & s_reg.sync) | (~direction_in & drive_value))
                & MASK;
            s_next.prev = s_reg.lvl;
            if (!armed) begin
                s_next.warm = s_reg.warm + 3'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level = s_reg.lvl;
    assign edge_event = (armed && ce) ?
        (((s_reg.lvl & ~s_reg.prev & rise_en) | (~s_reg.lvl & s_reg.prev & fall_en)) & MASK)
        : '0;

endmodule : pin_word_sampler

// ### tb/pin_model.sv
// far-side pad model: external levels reach the pins with a skew off the clock edge
`timescale 1ns/1ps
module pin_model #(
    parameter real SKEW_NS = 1.7
) (
    // levels the outside world wants
    input wire logic [31:0] target_banks01,
    input wire logic [15:0] target_bank2,
    // pads
    output wire logic [31:0] pin_in_banks01,
    output wire logic [15:0] pin_in_bank2
);
    // skew keeps pad changes clear of the sampling edge, unrelated to the clock
    assign #(SKEW_NS) pin_in_banks01 = target_banks01;
    assign #(SKEW_NS) pin_in_bank2 = target_bank2;
endmodule : pin_model

// ### tb/testbench.sv
// self-checking bench for the edge-interrupt bank
`timescale 1ns/1ps
module testbench;
    logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [gpio_edge_pkg::ADDR_W-1:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [31:0] wdata, rdata, tgt01, dir01, drv01, pin01;
    logic [15:0] tgt2, dir2, drv2, pin2;
    logic [31:0] pins [2], dirv [2], drvv [2], st [2], msk [2], en [2][2];
    int n_fail, checked;

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    gpio_edge_interrupt_bank dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pin_in_banks01(pin01), .pin_in_bank2(pin2),
        .pin_direction_banks01(dir01), .pin_direction_bank2(dir2),
        .pin_drive_banks01(drv01), .pin_drive_bank2(drv2), .irq(irq));

    pin_model pm (.target_banks01(tgt01), .target_bank2(tgt2),
        .pin_in_banks01(pin01), .pin_in_bank2(pin2));

    function automatic logic [31:0] wm(input int w);
        return gpio_edge_pkg::WORD_MASK[w];
    endfunction : wm

    function automatic logic [31:0] level_exp(input int w);
        return ((dirv[w] & pins[w]) | (~dirv[w] & drvv[w])) & wm(w);
    endfunction : level_exp

    function automatic logic [31:0] edge_exp(input logic [31:0] p0, p1, input int w);
        return ((~p0 & p1 & en[0][w]) | (p0 & ~p1 & en[1][w])) & wm(w);
    endfunction : edge_exp

    task close_out;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // handshakes judged at the falling edge, i.e. as the next rising edge samples them
    task automatic wr(input int a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        @(posedge aclk);
        awaddr <= 6'(a);
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_hs = 1'b0;
        while (b_hs !== 1'b1) begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input int a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        @(posedge aclk);
        araddr <= 6'(a);
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_hs = 1'b0;
        while (r_hs !== 1'b1) begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : rd

    task automatic rchk(input int a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(what, exp, d);
        chk("read response", 32'(gpio_edge_pkg::RESP_OKAY), 32'(r));
    endtask : rchk

    function automatic logic [31:0] strb_bits(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_bits

    // every enable, status and mask word as it stands after reset
    task automatic reset_view;
        logic [31:0] v;
        for (int w = 0; w < 2; w++) begin
            for (int o = 8; o < gpio_edge_pkg::OFF_LIMIT; o += 8) begin
                v = (o == gpio_edge_pkg::OFF_RISE_CLR || o == gpio_edge_pkg::OFF_FALL_CLR) ?
                    wm(w) : 32'h0000_0000;
                rchk(o + 4 * w, v, "reset value");
            end
        end
    endtask : reset_view

    // pads and pin configuration change together, then the sampler pipeline fills
    task apply;
        @(posedge aclk);
        tgt01 <= pins[0];
        tgt2 <= pins[1][15:0];
        dir01 <= dirv[0];
        dir2 <= dirv[1][15:0];
        drv01 <= drvv[0];
        drv2 <= drvv[1][15:0];
        repeat (6) @(posedge aclk);
    endtask : apply

    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        close_out();
    end

    initial begin
        logic [31:0] d, v, old;
        logic [1:0] r;
        logic [3:0] s;
        int k, w, base;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
        {awprot, arprot, wdata, tgt01, tgt2, drv01, drv2} = '0;
        {ce, wstrb, dir01, dir2} = '1;
        n_fail = 0;
        checked = 0;
        for (int i = 0; i < 2; i++) begin
            {pins[i], drvv[i], st[i], en[0][i], en[1][i]} = '0;
            dirv[i] = '1;
        end
        void'($urandom(65));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (gpio_edge_pkg::WARM_CYCLES) @(posedge aclk);
        reset_view();
        for (int i = 0; i < 6; i++) begin
            for (w = 0; w < 2; w++) begin
                pins[w] = $urandom;
                dirv[w] = (i == 0) ? '1 : ((i == 1) ? '0 : $urandom);
                drvv[w] = $urandom;
            end
            apply();
            for (w = 0; w < 2; w++) rchk(4 * w, level_exp(w), "pin level");
        end
        wr(gpio_edge_pkg::OFF_LEVEL, 32'hFFFF_FFFF, r);
        chk("level write response", 32'(gpio_edge_pkg::RESP_OKAY), 32'(r));
        rchk(gpio_edge_pkg::OFF_LEVEL, level_exp(0), "level after write");
        dirv[0] = '1;
        dirv[1] = '1;
        apply();
        for (int i = 0; i < 16; i++) begin
            // first eight reach every set and clear word once, then random
            k = (i < 8) ? i % 2 : $urandom_range(1);
            w = (i < 8) ? (i / 2) % 2 : $urandom_range(1);
            v = (i < 4) ? '1 : $urandom;
            s = (i < 4) ? 4'hF : 4'($urandom);
            wstrb <= s;
            v = v & strb_bits(s);
            base = k ? gpio_edge_pkg::OFF_FALL_SET : gpio_edge_pkg::OFF_RISE_SET;
            if (i < 4 || (i >= 8 && $urandom_range(1))) begin
                wr(base + 4 * w, v, r);
                en[k][w] = en[k][w] | (v & wm(w));
            end else begin
                wr(base + 8 + 4 * w, v, r);
                en[k][w] = en[k][w] & ~v;
            end
            rchk(base + 4 * w, en[k][w], "enable set view");
            rchk(base + 8 + 4 * w, ~en[k][w] & wm(w), "enable clear view");
        end
        wstrb <= 4'hF;
        for (int i = 0; i < 8; i++) begin
            for (w = 0; w < 2; w++) begin
                msk[w] = (i < 4) ? '1 : $urandom;
                wr(gpio_edge_pkg::OFF_MASK + 4 * w, msk[w], r);
                old = pins[w];
                pins[w] = (i == 0) ? ~old : $urandom;
                st[w] = st[w] | edge_exp(old, pins[w], w);
            end
            apply();
            for (w = 0; w < 2; w++) begin
                rchk(gpio_edge_pkg::OFF_PEND + 4 * w, st[w], "status");
            end
            @(negedge aclk);
            chk("irq", 32'(|((st[0] & msk[0]) | (st[1] & msk[1]))), 32'(irq));
            for (w = 0; w < 2; w++) begin
                v = $urandom;
                wr(gpio_edge_pkg::OFF_PEND + 4 * w, v, r);
                st[w] = st[w] & ~v;
                rchk(gpio_edge_pkg::OFF_PEND + 4 * w, st[w], "status after clear");
            end
            @(negedge aclk);
            chk("irq after clear", 32'(|((st[0] & msk[0]) | (st[1] & msk[1]))), 32'(irq));
        end
        // frozen cycle: no channel may accept anything
        @(posedge aclk);
        ce <= 1'b0;
        @(negedge aclk);
        chk("readies while frozen", 32'h0000_0000, 32'({awready, wready, arready}));
        @(posedge aclk);
        ce <= 1'b1;
        // second reset in mid-run must bring every word back to its reset view
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (gpio_edge_pkg::WARM_CYCLES) @(posedge aclk);
        for (w = 0; w < 2; w++) begin
            {st[w], en[0][w], en[1][w]} = '0;
        end
        reset_view();
        rchk(gpio_edge_pkg::OFF_LEVEL, level_exp(0), "level after reset");
        @(negedge aclk);
        chk("irq after reset", 32'h0000_0000, 32'(irq));
        wr(gpio_edge_pkg::OFF_LIMIT, $urandom, r);
        chk("unmapped write response", 32'(gpio_edge_pkg::RESP_DECERR), 32'(r));
        rd(gpio_edge_pkg::OFF_LIMIT + 4, d, r);
        chk("unmapped read data", 32'h0000_0000, d);
        chk("unmapped read response", 32'(gpio_edge_pkg::RESP_DECERR), 32'(r));
        close_out();
    end
endmodule : testbench
